// ---- src/tap_controller.sv ----
// Boundary-scan test access port: state machine, instruction register and data registers.
// Assumes CLK_SYS runs far faster than the test clock, which is sampled as a plain input.
// Summary of operation
// R1: Five high mode-select edges reach reset
// R2: Controller resets port after power-up
// R3: Port reset before normal queue operation
// R4: State changes on rising test clock
// R5: Reset state disables all test logic
// R6: Idle state acts only per instruction
// R7: Select states branch data, instruction, reset
// R8: Capture instruction loads pattern ending 01
// R9: Shift instruction moves bits in, out
// R10: Exit and pause states steer shifting
// R11: Update latches instruction on falling edge
// R12: Capture data loads selected register
// R13: Data path mirrors instruction path states
// R14: Instruction register is four bits
// R15: Data registers share serial in, out
// R16: Bypass is one stage, captures zero
// R17: Bypass shifting leaves device untouched
// R18: Boundary register loads and reads ports
// R19: Read-only 32-bit identification register
// R20: Version, part, maker, one at bit zero
// R21: Four inputs and one serial output
// R22: Offset instructions need serial programming idle; code flags them from the instruction alone
// R23: Bypass code selects bypass stage
// R24: Reset pin forces reset asynchronously
`timescale 1ns/1ps
`default_nettype none
module tap_controller
    import tap_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [BSR_WIDTH-1:0] PORT_IN,
    input wire logic [BSR_WIDTH-1:0] CORE_OUT,
    output logic [BSR_WIDTH-1:0] PORT_OUT,
    output logic PORT_HIGHZ,
    output logic TEST_ACTIVE,
    output logic OFFSET_ACCESS
);

    tap_pins_type sync1_reg, sync2_reg;
    logic tck_prev_reg;
    logic [1:0] trst_sync_reg;
    logic trst_n_s;
    logic tck_rise, tck_fall;
    tap_state_type state_reg, state_next;
    logic [2:0] tms_count_reg;
    logic [IR_WIDTH-1:0] ir_shift_reg, ir_reg;
    logic bypass_reg;
    logic [ID_WIDTH-1:0] id_shift_reg;
    logic [BSR_WIDTH-1:0] bsr_shift_reg, bsr_update_reg;
    logic tdo_next;
    logic sel_bsr, sel_id;

    localparam logic [ID_WIDTH-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_MARKER}; // [R20]

    // Two-stage sampling of test pins
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= '{tck: TCK, tms: TMS, tdi: TDI};
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg.tck;
        end
    end

    // Test reset pin: asserts at once, releases through two stages
    always_ff @(posedge CLK_SYS or negedge RSTN or negedge TRST_N) begin
        if (!RSTN || !TRST_N) begin
            trst_sync_reg <= 2'b00; // [R24]
        end else begin
            trst_sync_reg <= {trst_sync_reg[0], 1'b1};
        end
    end
    assign trst_n_s = trst_sync_reg[1];

    assign tck_rise = sync2_reg.tck && !tck_prev_reg; // [R4]
    assign tck_fall = !sync2_reg.tck && tck_prev_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TEST_LOGIC_RESET: state_next = sync2_reg.tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE; // [R1]
            RUN_TEST_IDLE: state_next = sync2_reg.tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: state_next = sync2_reg.tms ? SELECT_IR : CAPTURE_DR; // [R7]
            CAPTURE_DR: state_next = sync2_reg.tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: state_next = sync2_reg.tms ? EXIT1_DR : SHIFT_DR; // [R13]
            EXIT1_DR: state_next = sync2_reg.tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: state_next = sync2_reg.tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: state_next = sync2_reg.tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: state_next = sync2_reg.tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: state_next = sync2_reg.tms ? TEST_LOGIC_RESET : CAPTURE_IR; // [R7]
            CAPTURE_IR: state_next = sync2_reg.tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: state_next = sync2_reg.tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: state_next = sync2_reg.tms ? UPDATE_IR : PAUSE_IR; // [R10]
            PAUSE_IR: state_next = sync2_reg.tms ? EXIT2_IR : PAUSE_IR; // [R10]
            EXIT2_IR: state_next = sync2_reg.tms ? UPDATE_IR : SHIFT_IR; // [R10]
            UPDATE_IR: state_next = sync2_reg.tms ? SELECT_DR : RUN_TEST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= TEST_LOGIC_RESET;
        end else if (!trst_n_s) begin
            state_reg <= TEST_LOGIC_RESET; // [R24]
        end else if (tck_rise) begin
            state_reg <= state_next; // [R4]
        end
    end

    // Count of consecutive high mode-select edges
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            tms_count_reg <= 3'h0;
        end else if (!trst_n_s) begin
            tms_count_reg <= 3'h0;
        end else if (tck_rise) begin
            if (!sync2_reg.tms) begin
                tms_count_reg <= 3'h0;
            end else if (tms_count_reg != TMS_RESET_COUNT) begin
                tms_count_reg <= tms_count_reg + 3'h1;
            end
        end
    end

    // Instruction shift stages
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ir_shift_reg <= IR_CAPTURE;
        end else if (tck_rise) begin
            if (state_reg == CAPTURE_IR) begin
                ir_shift_reg <= IR_CAPTURE; // [R8]
            end else if (state_reg == SHIFT_IR) begin
                ir_shift_reg <= {sync2_reg.tdi, ir_shift_reg[IR_WIDTH-1:1]}; // [R9] [R14]
            end
        end
    end

    // Instruction latch, updated on falling test clock
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ir_reg <= IR_RESET;
        end else if (!trst_n_s || state_reg == TEST_LOGIC_RESET) begin
            ir_reg <= IR_RESET; // [R5]
        end else if (tck_fall && state_reg == UPDATE_IR) begin
            ir_reg <= ir_shift_reg; // [R11]
        end
    end

    // Instruction decode; unknown codes fall back to bypass
    assign sel_bsr = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE); // [R15]
    assign sel_id = (ir_reg == INS_IDCODE); // [R19]

    // Bypass stage
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            bypass_reg <= 1'b0;
        end else if (tck_rise && !sel_bsr && !sel_id) begin
            if (state_reg == CAPTURE_DR) begin
                bypass_reg <= 1'b0; // [R16] [R23]
            end else if (state_reg == SHIFT_DR) begin
                bypass_reg <= sync2_reg.tdi; // [R17]
            end
        end
    end

    // Identification shift, read only
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            id_shift_reg <= ID_VALUE;
        end else if (tck_rise && sel_id) begin
            if (state_reg == CAPTURE_DR) begin
                id_shift_reg <= ID_VALUE; // [R19]
            end else if (state_reg == SHIFT_DR) begin
                id_shift_reg <= {sync2_reg.tdi, id_shift_reg[ID_WIDTH-1:1]};
            end
        end
    end

    // Boundary-scan shift and update stages
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            bsr_shift_reg <= '0;
        end else if (tck_rise && sel_bsr) begin
            if (state_reg == CAPTURE_DR) begin
                bsr_shift_reg <= (ir_reg == INS_EXTEST) ? PORT_IN : CORE_OUT; // [R18] [R12]
            end else if (state_reg == SHIFT_DR) begin
                bsr_shift_reg <= {sync2_reg.tdi, bsr_shift_reg[BSR_WIDTH-1:1]}; // [R18]
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            bsr_update_reg <= '0;
        end else if (tck_fall && state_reg == UPDATE_DR && sel_bsr) begin
            bsr_update_reg <= bsr_shift_reg; // [R13]
        end
    end

    always_comb begin
        tdo_next = bypass_reg;
        if (state_reg == SHIFT_IR) begin
            tdo_next = ir_shift_reg[0];
        end else if (sel_id) begin
            tdo_next = id_shift_reg[0];
        end else if (sel_bsr) begin
            tdo_next = bsr_shift_reg[0]; // [R15]
        end
    end

    // Serial output changes on falling test clock
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO <= tdo_next; // [R21]
            TDO_OE <= (state_reg == SHIFT_IR) || (state_reg == SHIFT_DR);
        end
    end

    // Port drive: normal in reset and idle unless instruction drives pins
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            PORT_OUT <= '0;
            PORT_HIGHZ <= 1'b0;
            TEST_ACTIVE <= 1'b0;
            OFFSET_ACCESS <= 1'b0;
        end else begin
            TEST_ACTIVE <= (state_reg != TEST_LOGIC_RESET) && ((ir_reg == INS_EXTEST)
                || (ir_reg == INS_CLAMP)); // [R5] [R6]
            PORT_OUT <= TEST_ACTIVE ? bsr_update_reg : CORE_OUT;
            PORT_HIGHZ <= (state_reg != TEST_LOGIC_RESET) && (ir_reg == INS_HIGHZ);
            OFFSET_ACCESS <= (ir_reg == INS_OFS_READ) || (ir_reg == INS_OFS_WRITE); // [R22]
        end
    end

    // Count and state move together, so a full count means reset state now
    AST_TMS_RESET: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R1]
        (tms_count_reg == TMS_RESET_COUNT) |-> (state_reg == TEST_LOGIC_RESET))
        else $error("five high mode-select edges did not reach reset");

    AST_TRST: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R24]
        !trst_n_s |=> (state_reg == TEST_LOGIC_RESET))
        else $error("reset pin did not force reset state");

    AST_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R4]
        (!tck_rise && trst_n_s) |=> $stable(state_reg))
        else $error("state changed without rising test clock");

    sequence cap_ir_s;
        tck_rise && state_reg == CAPTURE_IR;
    endsequence
    AST_CAPTURE_IR: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R8]
        cap_ir_s |=> (ir_shift_reg[1:0] == 2'b01))
        else $error("captured instruction pattern not 01");

    AST_IR_SHIFT: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R9]
        (tck_rise && state_reg == SHIFT_IR) |=> (ir_shift_reg[3] == $past(sync2_reg.tdi)))
        else $error("instruction shift lost serial input");

    AST_IR_UPDATE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R11]
        (tck_fall && state_reg == UPDATE_IR && trst_n_s) |=> (ir_reg == $past(ir_shift_reg)))
        else $error("instruction not latched on update");

    AST_BYPASS_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R16]
        (tck_rise && state_reg == CAPTURE_DR && ir_reg == INS_BYPASS) |=> !bypass_reg)
        else $error("bypass stage did not capture zero");

    AST_ID_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R19]
        (tck_rise && state_reg == CAPTURE_DR && sel_id) |=> (id_shift_reg == ID_VALUE))
        else $error("identification value not captured");

    AST_ID_MARKER: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R20]
        (ID_VALUE[0] == 1'b1) && (ID_VALUE[11:1] == ID_MAKER))
        else $error("identification layout wrong");

    AST_RESET_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R5]
        (state_reg == TEST_LOGIC_RESET) [*2] |-> (!TEST_ACTIVE && !PORT_HIGHZ))
        else $error("test logic active in reset state");

    AST_SELECT_IR: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R7]
        (tck_rise && trst_n_s && state_reg == SELECT_IR && sync2_reg.tms)
        |=> (state_reg == TEST_LOGIC_RESET))
        else $error("select-instruction did not branch to reset");

    AST_IR_PAUSE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R10]
        (tck_rise && state_reg == PAUSE_IR) |=> $stable(ir_shift_reg))
        else $error("instruction shift moved while paused");

    AST_TDO_IR: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R9]
        (tck_fall && state_reg == SHIFT_IR) |=> (TDO == $past(ir_shift_reg[0])))
        else $error("serial output not fed from instruction stages");

    AST_TDO_ID: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R15]
        (tck_fall && state_reg == SHIFT_DR && sel_id) |=> (TDO == $past(id_shift_reg[0])))
        else $error("serial output not fed from identification stages");

    AST_TDO_OE_ON: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R21]
        (tck_fall && state_reg == SHIFT_DR) |=> TDO_OE)
        else $error("serial output not enabled while shifting");

    AST_TDO_OE_OFF: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R21]
        (tck_fall && state_reg == RUN_TEST_IDLE) |=> !TDO_OE)
        else $error("serial output enabled while idle");

    AST_BYPASS_SHIFT: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R23]
        (tck_rise && state_reg == SHIFT_DR && ir_reg == INS_BYPASS)
        |=> (bypass_reg == $past(sync2_reg.tdi)))
        else $error("bypass stage did not take serial input");

    AST_BYPASS_PORTS: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R17]
        (ir_reg == INS_BYPASS) [*2] |=> (PORT_OUT == $past(CORE_OUT)))
        else $error("bypass disturbed normal port drive");

    AST_IDLE_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R6]
        (state_reg == RUN_TEST_IDLE && sel_id) [*2] |-> (!TEST_ACTIVE && !PORT_HIGHZ))
        else $error("test logic active in idle without test instruction");

    AST_OFFSET: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R22]
        (ir_reg == INS_OFS_READ || ir_reg == INS_OFS_WRITE) |=> OFFSET_ACCESS)
        else $error("offset access not flagged");

    sequence cap_extest_s;
        tck_rise && state_reg == CAPTURE_DR && ir_reg == INS_EXTEST;
    endsequence
    AST_BSR_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R12]
        cap_extest_s |=> (bsr_shift_reg == $past(PORT_IN)))
        else $error("boundary cells did not capture port inputs");

    AST_BSR_PAUSE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R13]
        (tck_rise && state_reg == PAUSE_DR) |=> $stable(bsr_shift_reg))
        else $error("boundary shift moved while paused");

    sequence upd_dr_s;
        tck_fall && state_reg == UPDATE_DR && sel_bsr;
    endsequence
    AST_BSR_UPDATE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R13]
        upd_dr_s |=> (bsr_update_reg == $past(bsr_shift_reg)))
        else $error("boundary update stages not loaded");

    AST_EXTEST_DRIVE: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // [R18]
        TEST_ACTIVE |=> (PORT_OUT == $past(bsr_update_reg)))
        else $error("ports not driven from boundary update stages");

endmodule // tap_controller
`default_nettype wire

// ---- src/tap_pkg.sv ----
// Constants and types for the boundary-scan test access port.
// Assumes a single system clock that oversamples the test clock pin.
package tap_pkg;

    localparam int IR_WIDTH = 4;
    localparam int ID_WIDTH = 32;
    localparam int BSR_WIDTH = 8;

    // Instruction codes
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_SAMPLE = 4'h1;
    localparam logic [3:0] INS_IDCODE = 4'h2;
    localparam logic [3:0] INS_CLAMP = 4'h3;
    localparam logic [3:0] INS_HIGHZ = 4'h4;
    localparam logic [3:0] INS_OFS_READ = 4'h7;
    localparam logic [3:0] INS_OFS_WRITE = 4'h8;
    localparam logic [3:0] INS_BYPASS = 4'hf;

    // Capture pattern, low two bits fixed at 01
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_RESET = INS_IDCODE;

    // Identification fields; values arbitrary
    localparam logic [3:0] ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART = 16'h0123;
    localparam logic [10:0] ID_MAKER = 11'h05a;
    localparam logic ID_MARKER = 1'b1;

    localparam int TMS_RESET_EDGES = 5;
    localparam logic [2:0] TMS_RESET_COUNT = 3'h5;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_type;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_type;

endpackage

// ---- tb/tb_top.sv ----
// Self-checking bench for the test access port, driven through the controller model.
// Assumes the design package and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tap_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn;
    logic tck, tms, tdi, trst_n;
    logic tdo, tdo_oe, port_highz, test_active, offset_access;
    logic [BSR_WIDTH-1:0] port_in, core_out, port_out;
    logic [31:0] rd;
    logic [31:0] id_exp;
    logic [3:0] codes [5] = '{INS_HIGHZ, INS_OFS_READ, INS_OFS_WRITE, INS_BYPASS, INS_CLAMP};
    logic [2:0] modes [5] = '{3'h2, 3'h1, 3'h1, 3'h0, 3'h4};
    int error_cnt = 0;
    int compares = 0;

    always #2 clk_sys = ~clk_sys;

    tap_controller i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi),
        .TRST_N(trst_n), .TDO(tdo), .TDO_OE(tdo_oe), .PORT_IN(port_in), .CORE_OUT(core_out),
        .PORT_OUT(port_out), .PORT_HIGHZ(port_highz), .TEST_ACTIVE(test_active),
        .OFFSET_ACCESS(offset_access));

    test_ctrl i_ctrl (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic load_ir(input logic [3:0] code, input int pause_at);
        i_ctrl.scan(1'b1, 4, {28'h0, code}, pause_at, rd);
        check(rd, {28'h0, IR_CAPTURE});
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic check_modes(input logic [2:0] exp);
        check({29'h0, test_active, port_highz, offset_access}, {29'h0, exp});
    endtask

    task automatic check_id();
        i_ctrl.scan(1'b0, 32, 32'h0, -1, rd);
        check(rd, id_exp);
    endtask

    initial begin
        rstn = 1'b0;
        port_in = 8'h96;
        core_out = 8'h5c;
        id_exp = {ID_VERSION, ID_PART, ID_MAKER, ID_MARKER};
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        i_ctrl.test_reset();
        i_ctrl.tms_reset();
        repeat (4) @(posedge clk_sys);
        check_modes(3'h0);
        check({31'h0, tdo_oe}, 32'h0);
        i_ctrl.nav(4'b0000, 1);
        check_id();
        // Output enable while shifting data
        i_ctrl.nav(4'b0001, 3);
        repeat (12) @(posedge clk_sys);
        check({31'h0, tdo_oe}, 32'h1);
        i_ctrl.nav(4'b0011, 3);
        load_ir(INS_BYPASS, -1);
        i_ctrl.scan(1'b0, 8, 32'h6b, -1, rd);
        check(rd, 32'hd6);
        check({24'h0, port_out}, {24'h0, core_out});
        // Sample with pauses, then drive the preloaded value under external test
        load_ir(INS_SAMPLE, 1);
        i_ctrl.scan(1'b0, 8, 32'h3c, 4, rd);
        check(rd, {24'h0, core_out});
        load_ir(INS_EXTEST, -1);
        check_modes(3'h4);
        check({24'h0, port_out}, 32'h3c);
        i_ctrl.scan(1'b0, 8, 32'h00, -1, rd);
        check(rd, {24'h0, port_in});
        check({24'h0, port_out}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            load_ir(codes[k], -1);
            check_modes(modes[k]);
        end
        i_ctrl.scan(1'b0, 2, 32'h3, -1, rd);
        check(rd, 32'h2);
        // Test reset pin in mid data shift
        i_ctrl.nav(4'b0001, 3);
        i_ctrl.test_reset();
        repeat (4) @(posedge clk_sys);
        check_modes(3'h0);
        i_ctrl.nav(4'b0000, 1);
        check_id();
        // Reset branch from the instruction select state
        load_ir(INS_EXTEST, -1);
        i_ctrl.nav(4'b0111, 3);
        repeat (4) @(posedge clk_sys);
        check_modes(3'h0);
        // Five high mode-select edges from inside a data shift
        i_ctrl.nav(4'b0000, 1);
        load_ir(INS_EXTEST, -1);
        i_ctrl.nav(4'b0001, 3);
        i_ctrl.tms_reset();
        repeat (4) @(posedge clk_sys);
        check_modes(3'h0);
        complete_run();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// ---- tb/test_ctrl.sv ----
// Model of the external test controller: drives the test clock, mode select, data in and reset.
// Assumes the device oversamples these pins on its own fast system clock.
`timescale 1ns/1ps
`default_nettype none
module test_ctrl (
    input wire logic clk_sys,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // One test clock period of 68 ns; data out sampled just before the rise
    task automatic cycle(input logic m, input logic d, output logic q);
        @(posedge clk_sys);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk_sys);
        q = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge clk_sys);
        tck <= 1'b0;
    endtask

    // Mode-select walk, first bit first; data in toggles so no stale level lingers
    task automatic nav(input logic [3:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) cycle(seq[i], ~tdi, q);
    endtask

    task automatic test_reset();
        @(posedge clk_sys);
        trst_n <= 1'b0;
        repeat (13) @(posedge clk_sys);
        trst_n <= 1'b1;
        repeat (13) @(posedge clk_sys);
    endtask

    task automatic tms_reset();
        logic q;
        for (int i = 0; i < 5; i++) cycle(1'b1, 1'b0, q);
    endtask

    // From idle: scan n bits LSB first, optional pause after bit pause_at, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pause_at,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        nav(ir ? 4'b0011 : 4'b0001, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            cycle(i == n - 1 || i == pause_at, din[i], q);
            dout[i] = q;
            if (i == pause_at && i != n - 1) nav(4'b0100, 4);
        end
        nav(4'b0001, 2);
    endtask
endmodule // test_ctrl
`default_nettype wire
